// ---- pkg/ptb_pkg.sv ----
// constants and types of the pwm primary time base
// Function
// - module counts only while module_enable (control bit 15) is set
// - idle_stop set halts the time base while the cpu is idle
// - special_event_pending set by hardware, cleared by hardware, resets to zero
// - special event interrupt forwarded only while special_event_irq_enable is set
// - immediate_period_update loads period at once, else at cycle boundary
// - sync_polarity_invert makes sync input and output active low
// - sync output driven only while sync_output_enable is set
// - external_sync_enable restarts the time base on sync input
// - 16-bit period register, reset value with low three bits clear
// - 16-bit special event compare register, resets to zero
// - control bit 14 reads as zero
`default_nettype none
package ptb_pkg;
	// ----------------------------------------------------------------
	// register map (word byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CONTROL  = 4'h0;
	localparam logic [3:0] ADR_PERIOD   = 4'h4;
	localparam logic [3:0] ADR_COMPARE  = 4'h8;
	localparam logic [3:0] ADR_IRQ_STAT = 4'hc;
	localparam logic [3:0] ADR_IRQ_MASK = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
	localparam logic [3:0] ADR_MASK     = 4'h0;
	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int B_ENABLE   = 15;
	localparam int B_IDLE     = 13;
	localparam int B_PENDING  = 12;
	localparam int B_IRQ_EN   = 11;
	localparam int B_IMM      = 10;
	localparam int B_POL      = 9;
	localparam int B_SYNC_OE  = 8;
	localparam int B_SYNC_EN  = 7;
	localparam logic [15:0] CTRL_WMASK   = 16'hafff;
	localparam logic [15:0] PERIOD_RESET = 16'hfff8;
	localparam logic [15:0] ZERO16       = 16'h0000;
	localparam logic [15:0] ONE16        = 16'h0001;
	// status bits: 0 special event, 1 cycle boundary, 2 external sync
	localparam int          N_EVT        = 3;
	localparam logic [2:0]  EVT_ZERO     = 3'h0;
	localparam logic [4:0]  ADR_STAT5    = 5'h0c;
	localparam logic [4:0]  ADR_MASK5    = 5'h10;
	typedef enum logic [0:0] {
		ACK_IDLE = 1'b0,
		ACK_DONE = 1'b1
	} ptb_ack_t;
	typedef struct packed {
		ptb_ack_t    ack_st;
		logic [31:0] rdat;
		logic [15:0] ctrl;
		logic [15:0] period;
		logic        period_dirty;
		logic [15:0] active_period;
		logic [15:0] compare;
		logic [15:0] count;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic        irq;
		logic        sei;
		logic        sync_out;
		logic        sync_oe;
		logic [1:0]  sync_sh;
		logic [1:0]  idle_sh;
		logic        sync_prev;
		logic [3:0]  pend_cnt;
	} ptb_state_t;
endpackage : ptb_pkg
`default_nettype wire

// ---- hw/ptb_time_base.sv ----
// pwm primary time base with wishbone register slave
//
// Design decisions made here: the Wishbone register port and the register addresses.
`default_nettype none
module ptb_time_base
	import ptb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        cpu_idle_i,
	input  wire logic        sync_input_i,
	output logic             sync_output_o,
	output logic             sync_output_oe_o,
	output logic             special_event_irq_o,
	output logic             irq_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ptb_state_t s;
	ptb_state_t n;
	logic       req;
	logic       wr;
	logic       halted;
	logic       boundary;
	logic       sync_hit;
	logic       match;
	logic       sync_act;
	logic [15:0] wdat;
	logic [2:0]  evt;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		req = cyc_i && stb_i && (s.ack_st == ACK_IDLE);
		wr = req && we_i;
		wdat = ZERO16;
		// sync input after two flops; polarity applied
		sync_act = s.sync_sh[1] ^ s.ctrl[B_POL];
		sync_hit = s.ctrl[B_SYNC_EN] && sync_act && !s.sync_prev;
		halted = !s.ctrl[B_ENABLE] || (s.ctrl[B_IDLE] && s.idle_sh[1]);
		boundary = !halted && (s.count >= s.active_period || sync_hit);
		match = !halted && (s.count == s.compare);
		evt = {sync_hit && !halted, boundary, match};
		n.sync_sh = {s.sync_sh[0], sync_input_i};
		n.idle_sh = {s.idle_sh[0], cpu_idle_i};
		n.sync_prev = sync_act;
		// counter
		if (!halted) begin
			n.count = boundary ? ZERO16 : s.count + ONE16;
		end
		// period load
		if (boundary && s.period_dirty) begin
			n.active_period = s.period;
			n.period_dirty = 1'b0;
		end
		// special event pending: hardware set, hardware clear after a few cycles
		if (match) begin
			n.ctrl[B_PENDING] = 1'b1;
			n.pend_cnt = 4'hf;
		end else if (s.pend_cnt != 4'h0) begin
			n.pend_cnt = s.pend_cnt - 4'h1;
		end else begin
			n.ctrl[B_PENDING] = 1'b0;
		end
		// bus
		n.ack_st = req ? ACK_DONE : ACK_IDLE;
		if (req && !we_i) begin
			case (adr_i)
				5'h00:     n.rdat = {16'h0000, s.ctrl & ~16'h4000};
				5'h04:     n.rdat = {16'h0000, s.period};
				5'h08:     n.rdat = {16'h0000, s.compare};
				ADR_STAT5: n.rdat = {29'h0, s.stat};
				ADR_MASK5: n.rdat = {29'h0, s.mask};
				default:   n.rdat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (adr_i)
				5'h00: begin
					wdat = merge16(s.ctrl, dat_i, sel_i);
					n.ctrl = (wdat & CTRL_WMASK) | (n.ctrl & ~CTRL_WMASK);
				end
				5'h04: begin
					n.period = merge16(s.period, dat_i, sel_i);
					if (s.ctrl[B_IMM]) begin
						n.active_period = n.period;
						n.period_dirty = 1'b0;
					end else begin
						n.period_dirty = 1'b1;
					end
				end
				5'h08:     n.compare = merge16(s.compare, dat_i, sel_i);
				ADR_STAT5: n.stat = s.stat & ~(sel_i[0] ? dat_i[2:0] : EVT_ZERO);
				ADR_MASK5: n.mask = sel_i[0] ? dat_i[2:0] : s.mask;
				default:   n.mask = n.mask;
			endcase
		end
		n.stat = n.stat | evt; // set wins over clear
		n.irq = |(n.stat & n.mask);
		n.sei = n.ctrl[B_PENDING] && n.ctrl[B_IRQ_EN];
		// sync output: one pulse per boundary
		n.sync_oe = s.ctrl[B_SYNC_OE];
		n.sync_out = s.ctrl[B_SYNC_OE] ? (boundary ^ s.ctrl[B_POL]) : 1'b0;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.period <= PERIOD_RESET;
			s.active_period <= PERIOD_RESET;
		end else begin
			s <= n;
		end
	end

	assign dat_o = s.rdat;
	assign ack_o = s.ack_st == ACK_DONE;
	assign sync_output_o = s.sync_out;
	assign sync_output_oe_o = s.sync_oe;
	assign special_event_irq_o = s.sei;
	assign irq_o = s.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_disabled_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!s.ctrl[B_ENABLE] |=> s.count == $past(s.count))
		else $error("count moved while disabled");
	a_idle_halt: assert property (@(posedge clk_i) disable iff (rst_i)
		s.ctrl[B_IDLE] && s.idle_sh[1] |=> s.count == $past(s.count))
		else $error("count moved in idle");
	a_match_pend: assert property (@(posedge clk_i) disable iff (rst_i)
		match |=> s.ctrl[B_PENDING] && s.stat[0])
		else $error("match not flagged");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!s.ctrl[B_IRQ_EN] |-> !special_event_irq_o)
		else $error("event irq while disabled");
	a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		boundary |=> s.count == 16'h0000)
		else $error("no restart at boundary");
	a_imm_load: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == 5'h04 && s.ctrl[B_IMM] |=> s.active_period == s.period)
		else $error("immediate period not loaded");
	a_sync_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!s.ctrl[B_SYNC_OE] |=> !sync_output_oe_o && !sync_output_o)
		else $error("sync out while disabled");
	a_bit14_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && adr_i == 5'h00 |=> !dat_o[14] && ack_o)
		else $error("bit 14 read nonzero");
endmodule : ptb_time_base
`default_nettype wire

// ---- tb/ptb_sync_src.sv ----
// external sync source model
`default_nettype none
module ptb_sync_src (
	input  wire logic clk_i,
	input  wire logic low_i,
	input  wire logic fire_i,
	output logic      sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] left = 2'h0;
	always_ff @(posedge clk_i) begin
		left <= fire_i ? 2'h3 : left - {1'b0, left != 2'h0};
	end
	assign sync_o = (left != 2'h0) ^ low_i;
endmodule : ptb_sync_src
`default_nettype wire

// ---- tb/ptb_time_base_test.sv ----
// self-checking bench of the time base
`default_nettype none
module ptb_time_base_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, idle = 0, fire = 0, low = 0;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [15:0] q;
	logic        ack, so, soe, sei, irq, sin;
	int          mismatches = 0, comparisons = 0, n;
	ptb_time_base i_ptb_time_base (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.cpu_idle_i(idle), .sync_input_i(sin), .sync_output_o(so), .sync_output_oe_o(soe),
		.special_event_irq_o(sei), .irq_o(irq));
	ptb_sync_src i_ptb_sync_src (.clk_i(clk_i), .low_i(low), .fire_i(fire), .sync_o(sin));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= {16'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 0;
		stb <= 0;
	endtask : wb
	task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
		wb(0, a, 16'h0);
		chk(nm, e, q);
	endtask : rd
	task automatic gap(input logic act);
		n = 1;
		while (so !== act) @(posedge clk_i);
		@(posedge clk_i);
		while (so !== act) begin
			@(posedge clk_i);
			n++;
		end
		chk("gap", 16'h8, 16'(n));
	endtask : gap
	task automatic quiet(input string nm, ref logic s);
		n = 0;
		repeat (20) begin
			@(posedge clk_i);
			n += (s !== 1'b0);
		end
		chk(nm, 16'h0, 16'(n));
	endtask : quiet
	task automatic xsync(input logic [15:0] c, input logic e);
		wb(1, 5'h00, 16'h0);
		wb(1, 5'h00, c);
		wb(1, 5'h0c, 16'h7);
		wb(1, 5'h00, c | 16'h8000);
		fire <= 1;
		@(posedge clk_i);
		fire <= 0;
		repeat (8) @(posedge clk_i);
		rd(5'h0c, {13'h0, e, 2'h3}, "stat");
		chk("ext", {15'h0, e}, {15'h0, q[2]});
	endtask : xsync
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		rd(5'h00, 16'h0, "ctrl");
		rd(5'h04, 16'hfff8, "period");
		rd(5'h08, 16'h0, "compare");
		wb(1, 5'h00, 16'h7fff);
		rd(5'h00, 16'h2fff, "ctrl rw");
		wb(1, 5'h00, 16'h0400);
		wb(1, 5'h04, 16'h7);
		wb(1, 5'h08, 16'h3);
		wb(1, 5'h10, 16'h1);
		wb(1, 5'h00, 16'h8000);
		quiet("sei off", sei);
		chk("irq", 16'h1, {15'h0, irq});
		rd(5'h00, 16'h9000, "pending");
		wb(1, 5'h00, 16'h8800);
		chk("sei on", 16'h1, {15'h0, sei});
		wb(1, 5'h00, 16'h0);
		repeat (20) @(posedge clk_i);
		rd(5'h00, 16'h0, "hw clear");
		rd(5'h0c, 16'h3, "stat");
		wb(1, 5'h0c, 16'h7);
		@(posedge clk_i);
		chk("irq clr", 16'h0, {15'h0, irq});
		wb(1, 5'h00, 16'h0100);
		@(posedge clk_i);
		chk("oe", 16'h1, {15'h0, soe});
		wb(1, 5'h00, 16'h8100);
		gap(1);
		wb(1, 5'h00, 16'h0300);
		wb(1, 5'h00, 16'h8300);
		gap(0);
		wb(1, 5'h00, 16'h0);
		wb(1, 5'h00, 16'h8000);
		quiet("so off", so);
		wb(1, 5'h00, 16'h0);
		idle <= 1;
		wb(1, 5'h00, 16'h2100);
		wb(1, 5'h00, 16'ha100);
		repeat (4) @(posedge clk_i);
		quiet("idle", so);
		wb(1, 5'h00, 16'h8100);
		gap(1);
		idle <= 0;
		xsync(16'h0000, 0);
		xsync(16'h0080, 1);
		low <= 1;
		xsync(16'h0280, 1);
		print_verdict;
	end
endmodule : ptb_time_base_test
`default_nettype wire
